// ---- tb/omrb_host_model.sv ----
// Host controller model: issues single byte accesses to the register bank.
// Assumes the bank takes a request at the clock edge where a strobe is high.
`timescale 1ns/100ps
module omrb_host_model (
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  output omrb_pkg::omrb_req_t req
);
  initial
  begin
    req = '0;
  end
  // -----------------------------------------------------------------
  // Accesses
  // -----------------------------------------------------------------
  // A released request shows inverted fields so stale values never match.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a <= omrb_pkg::OFF_SETB)
    begin
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
    #1;
    d = reg_rdata;
  endtask
  // High byte is sign filled, then the low byte commits the code.
  task automatic margin(input logic [11:0] code);
    wr(omrb_pkg::OFF_MHIGH, {{4{code[11]}}, code[11:8]});
    wr(omrb_pkg::OFF_MLOW, code[7:0]);
  endtask
endmodule

// ---- tb/output_margin_register_bank_tb_top.sv ----
// Self-checking bench for the output margin register bank.
// Assumes the host model drives the register port; pins are driven here.
`timescale 1ns/100ps
module output_margin_register_bank_tb_top;
  logic clk;
  logic rst_n;
  omrb_pkg::omrb_req_t req;
  logic sync_pin, enable_pin, power_good_flag, margin_ramping;
  logic [3:0] fault_set;
  logic [2:0] band;
  logic [7:0] reg_rdata, converter_setup_a, converter_setup_b, rv;
  logic [11:0] margin_applied;
  omrb_pkg::omrb_strap_t freq_code, current_limit_code;
  omrb_pkg::omrb_strap_t softstart_code, comp_code;
  logic [6:0] slave_address;
  omrb_pkg::omrb_mode_t mode;
  int fails, samples_checked, b;

  omrb_host_model host (.clk(clk), .reg_rdata(reg_rdata), .req(req));
  omrb_top dut (.clk(clk), .rst_n(rst_n), .req(req), .sync_pin(sync_pin),
    .enable_pin(enable_pin), .power_good_flag(power_good_flag),
    .fault_set(fault_set), .frequency_select_strap(band),
    .current_limit_strap(~band), .softstart_lightload_strap(band + 3'h1),
    .compensation_strap(band), .reg_rdata(reg_rdata),
    .margin_applied(margin_applied), .margin_ramping(margin_ramping),
    .converter_setup_a(converter_setup_a),
    .converter_setup_b(converter_setup_b), .freq_code(freq_code),
    .current_limit_code(current_limit_code),
    .softstart_code(softstart_code),
    .comp_code(comp_code), .slave_address(slave_address), .mode(mode));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pins(input logic s, input logic e, input logic p);
    @(posedge clk);
    sync_pin <= s;
    enable_pin <= e;
    power_good_flag <= p;
    cyc(3);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, rv);
    chk({4'h0, rv}, {4'h0, exp});
  endtask
  // A ramp that never finishes ends the run instead of hanging it.
  // The first cycle lets a target committed at the call's edge raise the
  // ramping flag before it is tested.
  task automatic settle();
    cyc(1);
    for (int i = 0; i < 40000 && margin_ramping !== 1'b0; i++)
      cyc(1);
    if (margin_ramping !== 1'b0)
    begin
      fails++;
      close_out();
    end
  endtask
  // -----------------------------------------------------------------
  // Tests
  // -----------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    sync_pin = 1'b0;
    enable_pin = 1'b0;
    power_good_flag = 1'b0;
    fault_set = 4'h0;
    band = 3'h0;
    fails = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    cyc(2);
    chk({10'h000, mode}, {10'h000, omrb_pkg::OMRB_SHUTDOWN});
    for (b = 0; b < 8; b++)
    begin
      @(posedge clk);
      band <= 3'(b);
      cyc(3);
      chk({9'h000, freq_code}, 12'(b));
      chk({9'h000, current_limit_code}, 12'(7 - b));
      chk({9'h000, softstart_code}, 12'((b + 1) % 8));
      chk({9'h000, comp_code}, 12'(b));
      chk({5'h00, slave_address}, (b > 3) ? 12'h061 : 12'h060);
    end
    rchk(8'h00, 8'h5A);
    rchk(8'h04, 8'h0B);
    rchk(8'h05, 8'h2D);
    rchk(8'h07, 8'h00);
    $display("test reset_and_straps done");
    pins(1'b1, 1'b0, 1'b0);
    chk({10'h000, mode}, {10'h000, omrb_pkg::OMRB_PROGRAM});
    host.wr(8'h04, 8'hFF);
    rchk(8'h04, 8'h1F);
    host.wr(8'h05, 8'hA5);
    rchk(8'h05, 8'hA5);
    chk({4'h0, converter_setup_a}, 12'h01F);
    chk({4'h0, converter_setup_b}, 12'h0A5);
    host.wr(8'h00, 8'hFF);
    rchk(8'h00, 8'h5A);
    host.wr(8'h03, 8'h01);
    rchk(8'h03, 8'h00);
    chk(margin_applied, 12'h000);
    $display("test program_mode done");
    pins(1'b1, 1'b1, 1'b0);
    chk({10'h000, mode}, {10'h000, omrb_pkg::OMRB_CONVERT});
    host.wr(8'h03, 8'h01);
    cyc(150);
    chk(margin_applied, 12'h000);
    pins(1'b0, 1'b1, 1'b1);
    host.wr(8'h03, 8'h01);
    settle();
    chk(margin_applied, 12'h001);
    host.wr(8'h02, 8'h01);
    cyc(150);
    chk(margin_applied, 12'h001);
    host.wr(8'h02, 8'h11);
    rchk(8'h02, 8'h01);
    host.wr(8'h03, 8'h66);
    cyc(150);
    chk({margin_ramping, margin_applied}, 13'h1002);
    settle();
    chk(margin_applied, 12'h166);
    host.margin(12'hD34);
    cyc(150);
    chk({margin_ramping, margin_applied}, 13'h1165);
    rchk(8'h02, 8'hFD);
    $display("test margin done");
    @(posedge clk);
    fault_set <= 4'h5;
    @(posedge clk);
    fault_set <= 4'h0;
    cyc(1);
    rchk(8'h01, 8'h0B);
    host.wr(8'h01, 8'h02);
    rchk(8'h01, 8'h09);
    pins(1'b1, 1'b0, 1'b1);
    chk({10'h000, mode}, {10'h000, omrb_pkg::OMRB_PROGRAM});
    host.wr(8'h03, 8'h01);
    rchk(8'h03, 8'h34);
    pins(1'b0, 1'b0, 1'b1);
    chk({10'h000, mode}, {10'h000, omrb_pkg::OMRB_SHUTDOWN});
    chk(margin_applied, 12'h000);
    rchk(8'h02, 8'h00);
    rchk(8'h04, 8'h0B);
    rchk(8'h01, 8'h01);
    $display("test shutdown done");
    close_out();
  end
endmodule

// ---- verilog/omrb_pkg.sv ----
// Constants, types and register map of the output margin register bank.
// Assumes a single 100 MHz clock shared by every user of this package.
package omrb_pkg;
  // -----------------------------------------------------------------
  // Register map
  // -----------------------------------------------------------------
  localparam logic [7:0] OFF_REV = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h01;
  localparam logic [7:0] OFF_MHIGH = 8'h02;
  localparam logic [7:0] OFF_MLOW = 8'h03;
  localparam logic [7:0] OFF_SETA = 8'h04;
  localparam logic [7:0] OFF_SETB = 8'h05;
  // Revision code value is arbitrary.
  localparam logic [7:0] REVISION = 8'h5A;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MARGIN_RESET = 8'h00;
  localparam logic [7:0] SETA_RESET = 8'h0B;
  localparam logic [7:0] SETA_MASK = 8'h1F;
  localparam logic [7:0] SETB_RESET = 8'h2D;
  // -----------------------------------------------------------------
  // Field positions
  // -----------------------------------------------------------------
  localparam int PG_BIT = 0;
  localparam int FAULT_LSB = 1;
  localparam int FAULT_MSB = 4;
  localparam logic [3:0] FAULT_RESET = 4'h0;
  localparam int HI_MSB = 7;
  localparam int HI_RSV_LSB = 4;
  localparam int SIGN_BIT = 3;
  localparam int STRAP_ALT_BIT = 2;
  // -----------------------------------------------------------------
  // Margin range, slew timing and slave addresses
  // -----------------------------------------------------------------
  localparam logic [11:0] MARGIN_ZERO = 12'h000;
  localparam logic [11:0] MARGIN_MAX = 12'h166;
  localparam logic [11:0] MARGIN_MIN = 12'hD34;
  localparam logic [11:0] MARGIN_ONE = 12'h001;
  localparam int CLK_MHZ = 100;
  localparam int RAMP_STEP_NS = 1000;
  localparam int RAMP_STEP_CYCLES = (RAMP_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] RAMP_LAST = 8'(RAMP_STEP_CYCLES - 1);
  localparam logic [7:0] RAMP_CLR = 8'h00;
  localparam logic [6:0] ADDR_LOW = 7'h60;
  localparam logic [6:0] ADDR_HIGH = 7'h61;
  // -----------------------------------------------------------------
  // Types
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {OMRB_SHUTDOWN, OMRB_PROGRAM, OMRB_CONVERT}
    omrb_mode_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } omrb_req_t;
  typedef struct packed {
    logic alt;
    logic [1:0] code;
  } omrb_strap_t;
  localparam omrb_strap_t STRAP_RESET = 3'h0;
endpackage

// ---- verilog/omrb_top.sv ----
// Register bank behind the serial configuration port of a buck converter.
// Assumes a serial slave in front that delivers one byte access per
// request and treats every input as synchronous to clk.
`timescale 1ns/100ps
module omrb_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire omrb_pkg::omrb_req_t req,
  input wire logic sync_pin,
  input wire logic enable_pin,
  input wire logic power_good_flag,
  input wire logic [3:0] fault_set,
  input wire logic [2:0] frequency_select_strap,
  input wire logic [2:0] current_limit_strap,
  input wire logic [2:0] softstart_lightload_strap,
  input wire logic [2:0] compensation_strap,
  output logic [7:0] reg_rdata,
  output logic [11:0] margin_applied,
  output logic margin_ramping,
  output logic [7:0] converter_setup_a,
  output logic [7:0] converter_setup_b,
  output omrb_pkg::omrb_strap_t freq_code,
  output omrb_pkg::omrb_strap_t current_limit_code,
  output omrb_pkg::omrb_strap_t softstart_code,
  output omrb_pkg::omrb_strap_t comp_code,
  output logic [6:0] slave_address,
  output omrb_pkg::omrb_mode_t mode
);
  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  function automatic omrb_pkg::omrb_strap_t strap_decode(
    input logic [2:0] band);
    omrb_pkg::omrb_strap_t s;
    s.alt = band[omrb_pkg::STRAP_ALT_BIT];
    s.code = band[1:0];
    return s;
  endfunction

  // Out-of-range codes are pinned to the nearest limit rather than
  // dropped, so a sloppy host still gets a bounded output.
  function automatic logic [11:0] clamp_margin(input logic [11:0] c);
    logic [11:0] r;
    r = c;
    if ($signed(c) > $signed(omrb_pkg::MARGIN_MAX))
      r = omrb_pkg::MARGIN_MAX;
    else if ($signed(c) < $signed(omrb_pkg::MARGIN_MIN))
      r = omrb_pkg::MARGIN_MIN;
    return r;
  endfunction

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  omrb_pkg::omrb_mode_t next_mode;
  logic [7:0] margin_high, next_margin_high;
  logic [7:0] margin_low, next_margin_low;
  logic [11:0] margin_target, next_margin_target;
  logic [11:0] next_margin_applied;
  logic next_margin_ramping;
  logic [7:0] ramp_count, next_ramp_count;
  logic [3:0] fault_flags, next_fault_flags;
  logic pg_q, next_pg_q;
  logic [7:0] next_converter_setup_a, next_converter_setup_b;
  logic [7:0] next_reg_rdata;
  omrb_pkg::omrb_strap_t next_freq_code, next_current_limit_code;
  omrb_pkg::omrb_strap_t next_softstart_code, next_comp_code;
  logic [6:0] next_slave_address;
  logic port_active, margin_open, config_open, high_ok;
  logic wr_high, wr_low;

  always_comb
  begin
    port_active = (mode != omrb_pkg::OMRB_SHUTDOWN);
    margin_open = (mode == omrb_pkg::OMRB_CONVERT) && pg_q;
    config_open = (mode == omrb_pkg::OMRB_PROGRAM);
    high_ok = (req.wdata[omrb_pkg::HI_MSB:omrb_pkg::HI_RSV_LSB] ==
               {4{req.wdata[omrb_pkg::SIGN_BIT]}});
    wr_high = req.wr && margin_open && (req.addr == omrb_pkg::OFF_MHIGH);
    wr_low = req.wr && margin_open && (req.addr == omrb_pkg::OFF_MLOW);

    next_mode = mode;
    case (mode)
      omrb_pkg::OMRB_SHUTDOWN:
      begin
        if (enable_pin)
        begin
          next_mode = omrb_pkg::OMRB_CONVERT;
        end
        else if (sync_pin)
        begin
          next_mode = omrb_pkg::OMRB_PROGRAM;
        end
      end
      omrb_pkg::OMRB_PROGRAM:
      begin
        if (enable_pin)
        begin
          next_mode = omrb_pkg::OMRB_CONVERT;
        end
        else if (!sync_pin)
        begin
          next_mode = omrb_pkg::OMRB_SHUTDOWN;
        end
      end
      default:
      begin
        if (!enable_pin)
        begin
          next_mode = sync_pin ? omrb_pkg::OMRB_PROGRAM
                               : omrb_pkg::OMRB_SHUTDOWN;
        end
      end
    endcase

    next_pg_q = power_good_flag;
    next_margin_high = margin_high;
    next_margin_low = margin_low;
    next_margin_target = margin_target;
    next_converter_setup_a = converter_setup_a;
    next_converter_setup_b = converter_setup_b;
    next_fault_flags = fault_flags;
    next_freq_code = freq_code;
    next_current_limit_code = current_limit_code;
    next_softstart_code = softstart_code;
    next_comp_code = comp_code;

    // Status flags clear on a written one; a new fault in the same
    // cycle still lands.
    if (req.wr && port_active && (req.addr == omrb_pkg::OFF_STATUS))
    begin
      next_fault_flags = fault_flags &
        ~req.wdata[omrb_pkg::FAULT_MSB:omrb_pkg::FAULT_LSB];
    end
    next_fault_flags = next_fault_flags | fault_set;

    if (wr_high && high_ok)
    begin
      next_margin_high = req.wdata;
    end
    if (wr_low)
    begin
      next_margin_low = req.wdata;
      next_margin_target = clamp_margin(
        {margin_high[omrb_pkg::SIGN_BIT:0], req.wdata});
    end
    if (req.wr && config_open && (req.addr == omrb_pkg::OFF_SETA))
    begin
      next_converter_setup_a = req.wdata & omrb_pkg::SETA_MASK;
    end
    if (req.wr && config_open && (req.addr == omrb_pkg::OFF_SETB))
    begin
      next_converter_setup_b = req.wdata;
    end

    if (mode == omrb_pkg::OMRB_SHUTDOWN)
    begin
      next_margin_high = omrb_pkg::MARGIN_RESET;
      next_margin_low = omrb_pkg::MARGIN_RESET;
      next_margin_target = omrb_pkg::MARGIN_ZERO;
      next_converter_setup_a = omrb_pkg::SETA_RESET;
      next_converter_setup_b = omrb_pkg::SETB_RESET;
      next_fault_flags = omrb_pkg::FAULT_RESET;
      next_freq_code = strap_decode(frequency_select_strap);
      next_current_limit_code = strap_decode(current_limit_strap);
      next_softstart_code = strap_decode(softstart_lightload_strap);
      next_comp_code = strap_decode(compensation_strap);
    end
    next_slave_address = next_comp_code.alt ? omrb_pkg::ADDR_HIGH
                                            : omrb_pkg::ADDR_LOW;

    // One step per slew period keeps the transition at the soft-start
    // rate; a shutdown snaps back to zero since conversion has stopped.
    next_ramp_count = ramp_count;
    next_margin_applied = margin_applied;
    if (mode == omrb_pkg::OMRB_SHUTDOWN)
    begin
      next_ramp_count = omrb_pkg::RAMP_CLR;
      next_margin_applied = omrb_pkg::MARGIN_ZERO;
    end
    else if (margin_applied == margin_target)
    begin
      next_ramp_count = omrb_pkg::RAMP_CLR;
    end
    else if (ramp_count != omrb_pkg::RAMP_LAST)
    begin
      next_ramp_count = ramp_count + 8'h01;
    end
    else
    begin
      next_ramp_count = omrb_pkg::RAMP_CLR;
      if ($signed(margin_target) > $signed(margin_applied))
      begin
        next_margin_applied = margin_applied + omrb_pkg::MARGIN_ONE;
      end
      else
      begin
        next_margin_applied = margin_applied - omrb_pkg::MARGIN_ONE;
      end
    end
    next_margin_ramping = (next_margin_applied != next_margin_target);

    next_reg_rdata = reg_rdata;
    if (req.rd)
    begin
      if (req.addr == omrb_pkg::OFF_REV)
        next_reg_rdata = omrb_pkg::REVISION;
      else if (req.addr == omrb_pkg::OFF_STATUS)
        next_reg_rdata = {3'h0, fault_flags, pg_q};
      else if (req.addr == omrb_pkg::OFF_MHIGH)
        next_reg_rdata = margin_high;
      else if (req.addr == omrb_pkg::OFF_MLOW)
        next_reg_rdata = margin_low;
      else if (req.addr == omrb_pkg::OFF_SETA)
        next_reg_rdata = converter_setup_a;
      else if (req.addr == omrb_pkg::OFF_SETB)
        next_reg_rdata = converter_setup_b;
      else
        next_reg_rdata = omrb_pkg::ZERO_BYTE;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mode <= omrb_pkg::OMRB_SHUTDOWN;
      margin_high <= omrb_pkg::MARGIN_RESET;
      margin_low <= omrb_pkg::MARGIN_RESET;
      margin_target <= omrb_pkg::MARGIN_ZERO;
      margin_applied <= omrb_pkg::MARGIN_ZERO;
      margin_ramping <= 1'b0;
      ramp_count <= omrb_pkg::RAMP_CLR;
      fault_flags <= omrb_pkg::FAULT_RESET;
      pg_q <= 1'b0;
      converter_setup_a <= omrb_pkg::SETA_RESET;
      converter_setup_b <= omrb_pkg::SETB_RESET;
      reg_rdata <= omrb_pkg::ZERO_BYTE;
      freq_code <= omrb_pkg::STRAP_RESET;
      current_limit_code <= omrb_pkg::STRAP_RESET;
      softstart_code <= omrb_pkg::STRAP_RESET;
      comp_code <= omrb_pkg::STRAP_RESET;
      slave_address <= omrb_pkg::ADDR_LOW;
    end
    else
    begin
      mode <= next_mode;
      margin_high <= next_margin_high;
      margin_low <= next_margin_low;
      margin_target <= next_margin_target;
      margin_applied <= next_margin_applied;
      margin_ramping <= next_margin_ramping;
      ramp_count <= next_ramp_count;
      fault_flags <= next_fault_flags;
      pg_q <= next_pg_q;
      converter_setup_a <= next_converter_setup_a;
      converter_setup_b <= next_converter_setup_b;
      reg_rdata <= next_reg_rdata;
      freq_code <= next_freq_code;
      current_limit_code <= next_current_limit_code;
      softstart_code <= next_softstart_code;
      comp_code <= next_comp_code;
      slave_address <= next_slave_address;
    end
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_power_good_gate: assert property (
    req.wr && !pg_q && (mode == omrb_pkg::OMRB_CONVERT) |=>
      $stable(margin_target) && $stable(margin_high))
    else $error("margin changed before power good");
  a_program_ro: assert property (
    req.wr && (mode == omrb_pkg::OMRB_PROGRAM) |=>
      $stable(margin_high) && $stable(margin_low))
    else $error("margin written in configuration mode");
  a_high_only: assert property (
    wr_high |=> $stable(margin_target))
    else $error("high byte alone moved the margin");
  a_margin_range: assert property (
    ($signed(margin_target) <= $signed(omrb_pkg::MARGIN_MAX)) &&
    ($signed(margin_target) >= $signed(omrb_pkg::MARGIN_MIN)))
    else $error("margin target out of range");
  a_ramp_slew: assert property (
    (mode != omrb_pkg::OMRB_SHUTDOWN) && (margin_applied != margin_target)
    |=> (margin_applied == $past(margin_applied)) ||
        (ramp_count == omrb_pkg::RAMP_CLR))
    else $error("applied margin moved off the slew period");
  a_low_step: assert property (
    wr_low && (req.wdata == 8'h01) &&
    (margin_high == omrb_pkg::MARGIN_RESET) |=>
      margin_target == omrb_pkg::MARGIN_ONE)
    else $error("single low write did not step by one");
  a_strap_decode: assert property (
    mode == omrb_pkg::OMRB_SHUTDOWN |=>
      freq_code == strap_decode($past(frequency_select_strap)))
    else $error("strap band decoded wrongly");
  a_revision_ro: assert property (
    req.rd && (req.addr == omrb_pkg::OFF_REV) |=>
      reg_rdata == omrb_pkg::REVISION)
    else $error("revision register read back wrong");
  a_sign_check: assert property (
    wr_high && !high_ok |=> $stable(margin_high))
    else $error("badly sign-extended high byte accepted");
  a_address_sel: assert property (
    slave_address == (comp_code.alt ? omrb_pkg::ADDR_HIGH
                                    : omrb_pkg::ADDR_LOW))
    else $error("slave address does not follow strap");
  a_config_entry: assert property (
    (mode == omrb_pkg::OMRB_SHUTDOWN) && sync_pin && !enable_pin |=>
      mode == omrb_pkg::OMRB_PROGRAM)
    else $error("configuration mode not entered");
  a_shutdown_dflt: assert property (
    mode == omrb_pkg::OMRB_SHUTDOWN |=>
      (converter_setup_a == omrb_pkg::SETA_RESET) &&
      (margin_target == omrb_pkg::MARGIN_ZERO))
    else $error("defaults not restored in shutdown");
endmodule
